/* core/efsc_stat_counters.sv */
// Functional notes
// - counters change only when a transmit or receive frame report completes; the code also clears them on a dump-and-reset command
// - counters reach software only through a dump or dump-and-reset command
// - good-transmit counter counts frames finished on the link
// - count frames abandoned at the maximum collision limit
// - count frames abandoned for a collision after the slot time
// - count each underrun report, possibly several per frame
// - count good frames sent while carrier dropped
// - count frames deferred because the link was busy
// - good frames with one collision count single, more count multiple
// - total collisions adds every collision of every attempt
// - good-receive counts frames fully received and stored
// - crc counter counts aligned frames failing crc
// - alignment counter counts misaligned frames failing crc
// - short frames count only as short; crc, align, short exclusive
// - count good frames dropped for lack of resources
// - no resource count for a bad frame when saving bad frames
// - overrun counter counts each flagged lost frame
// - count frames with a collision during reception
// - counters are 32 bits and wrap to zero
// - counters clear on reset; no preload other than zero
// - every applicable counter of one frame updates together
// - a dump writes 16 or 21 words per configuration
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "efsc_cfg.svh"

module efsc_stat_counters
  import efsc_pkg::*;
#(
  parameter int NCNT = 21,
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire efsc_tx_rpt_t tx_rpt_i,
  input wire efsc_rx_rpt_t rx_rpt_i,
  output efsc_dump_t dump_o,
  output logic dump_valid_o,
  input wire logic dump_ready_i
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (NCNT != 21) begin : g_bad_ncnt
    $error("efsc_stat_counters: NCNT must be 21");
  end
  if (AW < 8) begin : g_bad_aw
    $error("efsc_stat_counters: AW must be at least 8");
  end

  function automatic int ix(input logic [7:0] ofs);
    return int'(ofs[7:2]);
  endfunction : ix

  // ****************************************************************
  // apb slave and control registers
  // ****************************************************************
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [31:0] base_r, base_nxt;
  logic [15:0] dumps_r, dumps_nxt;
  logic access, wr_go, mapped;
  logic [7:0] addr8;
  logic busy;
  efsc_state_t state_r, state_nxt;

  assign addr8 = paddr_i[7:0];
  assign access = psel_i & penable_i & ~pready_r;
  assign wr_go = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;
  assign busy = (state_r != EFSC_IDLE);
  assign mapped = (addr8 == `EFSC_REG_CTRL) | (addr8 == `EFSC_REG_DUMP_BASE) |
                  (addr8 == `EFSC_REG_CMD) | (addr8 == `EFSC_REG_STATUS);

  // one wait state, then answer with data or error
  always_comb begin
    pready_nxt = access;
    pslverr_nxt = access & ~mapped;
    prdata_nxt = prdata_r;
    ctrl_nxt = ctrl_r;
    base_nxt = base_r;
    if (access) begin
      prdata_nxt = 32'h0000_0000;
      unique case (addr8)
        `EFSC_REG_CTRL: prdata_nxt[2:0] = ctrl_r;
        `EFSC_REG_DUMP_BASE: prdata_nxt = base_r;
        `EFSC_REG_STATUS: begin
          prdata_nxt[`EFSC_STAT_BUSY_BIT] = busy;
          prdata_nxt[`EFSC_STAT_DUMPS_LSB +: 16] = dumps_r;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_go && addr8 == `EFSC_REG_CTRL) begin
      ctrl_nxt = pwdata_i[2:0];
    end
    if (wr_go && addr8 == `EFSC_REG_DUMP_BASE) begin
      base_nxt = {pwdata_i[31:2], 2'h0};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ctrl_r <= `EFSC_CTRL_RST;
      base_r <= `EFSC_BASE_RST;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      ctrl_r <= ctrl_nxt;
      base_r <= base_nxt;
    end
  end

  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign prdata_o = prdata_r;

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic cmd_dump, cmd_clear;

  // a command written while a dump runs is dropped
  always_comb begin
    cmd_dump = 1'b0;
    cmd_clear = 1'b0;
    if (wr_go && addr8 == `EFSC_REG_CMD && !busy) begin
      cmd_dump = (pwdata_i[3:0] == `EFSC_OP_DUMP) | (pwdata_i[3:0] == `EFSC_OP_DUMP_RESET);
      cmd_clear = (pwdata_i[3:0] == `EFSC_OP_DUMP_RESET);
    end
  end

  // ****************************************************************
  // per-frame increments
  // ****************************************************************
  logic [31:0] inc [NCNT];
  logic tx_go, rx_go, savebad;

  assign tx_go = tx_rpt_i.done;
  assign rx_go = rx_rpt_i.done;
  assign savebad = ctrl_r[`EFSC_CTRL_SAVEBAD_BIT];

  // all counters that apply to one report step in the same cycle
  always_comb begin
    for (int k = 0; k < NCNT; k++) begin
      inc[k] = 32'h0000_0000;
    end
    if (tx_go) begin
      inc[ix(`EFSC_OFS_TX_GOOD)] = {31'h0, tx_rpt_i.good};
      inc[ix(`EFSC_OFS_TX_MAXCOLL)] = {31'h0, tx_rpt_i.excess_collision_abort};
      inc[ix(`EFSC_OFS_TX_LATECOLL)] = {31'h0, tx_rpt_i.late_collision_abort};
      inc[ix(`EFSC_OFS_TX_UNDERRUN)] = {31'h0, tx_rpt_i.underrun};
      inc[ix(`EFSC_OFS_TX_LOSTCRS)] = {31'h0, tx_rpt_i.good & tx_rpt_i.lost_carrier};
      inc[ix(`EFSC_OFS_TX_DEFER)] = {31'h0, tx_rpt_i.deferred};
      inc[ix(`EFSC_OFS_TX_SINGLE)] =
        {31'h0, tx_rpt_i.good & (tx_rpt_i.coll_count == 5'h01)};
      inc[ix(`EFSC_OFS_TX_MULTI)] =
        {31'h0, tx_rpt_i.good & (tx_rpt_i.coll_count > 5'h01)};
      inc[ix(`EFSC_OFS_TX_TOTCOLL)] = {27'h0, tx_rpt_i.coll_count};
      inc[ix(`EFSC_OFS_FC_TX_PAUSE)] = {31'h0, tx_rpt_i.flow_pause};
      inc[ix(`EFSC_OFS_TX_MGMT)] = {31'h0, tx_rpt_i.mgmt};
    end
    if (rx_go) begin
      inc[ix(`EFSC_OFS_RX_GOOD)] = {31'h0, rx_rpt_i.good};
      inc[ix(`EFSC_OFS_RX_SHORT)] = {31'h0, rx_rpt_i.short_frame};
      inc[ix(`EFSC_OFS_RX_ALIGN)] = {31'h0, ~rx_rpt_i.short_frame & rx_rpt_i.align_err &
                                     rx_rpt_i.crc_err};
      inc[ix(`EFSC_OFS_RX_CRC)] = {31'h0, ~rx_rpt_i.short_frame & ~rx_rpt_i.align_err &
                                   rx_rpt_i.crc_err};
      inc[ix(`EFSC_OFS_RX_RESRC)] = {31'h0, rx_rpt_i.resource_err &
                                     ~(savebad & rx_rpt_i.bad_frame)};
      inc[ix(`EFSC_OFS_RX_OVERRUN)] = {31'h0, rx_rpt_i.overrun};
      inc[ix(`EFSC_OFS_RX_COLL)] = {31'h0, rx_rpt_i.receive_collision_seen};
      inc[ix(`EFSC_OFS_FC_RX_PAUSE)] = {31'h0, rx_rpt_i.flow_pause};
      inc[ix(`EFSC_OFS_FC_RX_UNSUP)] = {31'h0, rx_rpt_i.flow_unsup};
      inc[ix(`EFSC_OFS_RX_MGMT)] = {31'h0, rx_rpt_i.mgmt};
    end
  end

  // ****************************************************************
  // counters and dump snapshot
  // ****************************************************************
  logic [31:0] cnt_r [NCNT];
  logic [31:0] snap_r [NCNT];

  for (genvar g = 0; g < NCNT; g++) begin : g_cnt
    logic [31:0] cnt_nxt, snap_nxt;
    // clear and count in one step, so an event in the clear cycle survives
    always_comb begin
      snap_nxt = cmd_dump ? cnt_r[g] : snap_r[g];
      cnt_nxt = (cmd_clear ? 32'h0000_0000 : cnt_r[g]) + inc[g];
    end
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        cnt_r[g] <= 32'h0000_0000;
        snap_r[g] <= 32'h0000_0000;
      end else begin
        cnt_r[g] <= cnt_nxt;
        snap_r[g] <= snap_nxt;
      end
    end
  end

  // ****************************************************************
  // dump engine
  // ****************************************************************
  logic [4:0] idx_r, idx_nxt;
  logic [4:0] last_r, last_nxt;
  logic dv_r, dv_nxt;
  efsc_dump_t dw_r, dw_nxt;
  logic ext_dump;

  assign ext_dump = ctrl_r[`EFSC_CTRL_EXT_BIT] | ctrl_r[`EFSC_CTRL_MGMT_BIT];

  // walk the snapshot, one word per handshake
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    dv_nxt = dv_r;
    dw_nxt = dw_r;
    dumps_nxt = dumps_r;
    unique case (state_r)
      EFSC_IDLE: begin
        if (cmd_dump) begin
          idx_nxt = 5'h00;
          last_nxt = (ext_dump ? `EFSC_WORDS_EXT : `EFSC_WORDS_BASIC) - 5'h01;
          state_nxt = EFSC_LOAD;
        end
      end
      EFSC_LOAD: begin
        dw_nxt.addr = base_r + {25'h0, idx_r, 2'h0};
        dw_nxt.data = snap_r[idx_r];
        dv_nxt = 1'b1;
        state_nxt = EFSC_WRITE;
      end
      EFSC_WRITE: begin
        if (dump_ready_i) begin
          dv_nxt = 1'b0;
          idx_nxt = idx_r + 5'h01;
          if (idx_r == last_r) begin
            dumps_nxt = dumps_r + 16'h0001;
            state_nxt = EFSC_IDLE;
          end else begin
            state_nxt = EFSC_LOAD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= EFSC_IDLE;
      idx_r <= 5'h00;
      last_r <= 5'h00;
      dv_r <= 1'b0;
      dw_r <= '0;
      dumps_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      dv_r <= dv_nxt;
      dw_r <= dw_nxt;
      dumps_r <= dumps_nxt;
    end
  end

  assign dump_o = dw_r;
  assign dump_valid_o = dv_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_tx_good_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_go && tx_rpt_i.good && !cmd_clear) |=>
      cnt_r[ix(`EFSC_OFS_TX_GOOD)] == $past(cnt_r[ix(`EFSC_OFS_TX_GOOD)]) + 32'h1)
    else $error("good transmit count did not step");
  a_idle_no_change: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!tx_go && !rx_go && !cmd_clear) |=> cnt_r[ix(`EFSC_OFS_RX_GOOD)] ==
      $past(cnt_r[ix(`EFSC_OFS_RX_GOOD)]))
    else $error("counter moved without a frame report");
  a_tot_coll_sum: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_go && !cmd_clear) |=> cnt_r[ix(`EFSC_OFS_TX_TOTCOLL)] ==
      $past(cnt_r[ix(`EFSC_OFS_TX_TOTCOLL)]) + {27'h0, $past(tx_rpt_i.coll_count)})
    else $error("total collisions not summed");
  a_rx_err_excl: assert property (@(posedge mclk_i) disable iff (rst_i)
    $onehot0({inc[ix(`EFSC_OFS_RX_CRC)][0], inc[ix(`EFSC_OFS_RX_ALIGN)][0],
              inc[ix(`EFSC_OFS_RX_SHORT)][0]}))
    else $error("crc, align and short counted together");
  a_savebad_resrc: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rx_go && savebad && rx_rpt_i.bad_frame && !cmd_clear) |=>
      cnt_r[ix(`EFSC_OFS_RX_RESRC)] == $past(cnt_r[ix(`EFSC_OFS_RX_RESRC)]))
    else $error("resource error counted for saved bad frame");
  a_clear_keeps: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cmd_clear && rx_go && rx_rpt_i.good) |=>
      (cnt_r[ix(`EFSC_OFS_RX_GOOD)] == 32'h1) &&
      (snap_r[ix(`EFSC_OFS_RX_GOOD)] == $past(cnt_r[ix(`EFSC_OFS_RX_GOOD)])))
    else $error("event lost at dump-and-reset");
  // a full count is out of reach in a run, so check the step modulo the width instead
  a_wrap_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rx_go && rx_rpt_i.overrun && !cmd_clear) |=> cnt_r[ix(`EFSC_OFS_RX_OVERRUN)] ==
      $past(cnt_r[ix(`EFSC_OFS_RX_OVERRUN)]) + 32'h0000_0001)
    else $error("overrun count did not step modulo its width");
  a_dump_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    dv_r |-> dw_r.addr == base_r + {25'h0, idx_r, 2'h0})
    else $error("dump word at wrong address");
  a_dump_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_dump |=> last_r == (ext_dump ? 5'h14 : 5'h0F))
    else $error("dump length wrong");
  a_dump_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (dv_r && !dump_ready_i) |=> dv_r && $stable(dw_r))
    else $error("dump word dropped before handshake");
  a_apb_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
    (psel_i && penable_i && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("apb answer not one cycle");

  c_dump_reset: cover property (@(posedge mclk_i) disable iff (rst_i) cmd_clear);
  c_both_frames: cover property (@(posedge mclk_i) disable iff (rst_i) tx_go && rx_go);
  c_dump_done: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_r == EFSC_WRITE && dump_ready_i && idx_r == 5'h14);
  c_unmapped: cover property (@(posedge mclk_i) disable iff (rst_i) pslverr_r);

endmodule : efsc_stat_counters
`default_nettype wire

/* core/efsc_cfg.svh */
`ifndef EFSC_CFG_SVH
`define EFSC_CFG_SVH

// ****************************************************************
// counter dump offsets (bytes from the dump base)
// ****************************************************************
`define EFSC_OFS_TX_GOOD 8'h00
`define EFSC_OFS_TX_MAXCOLL 8'h04
`define EFSC_OFS_TX_LATECOLL 8'h08
`define EFSC_OFS_TX_UNDERRUN 8'h0C
`define EFSC_OFS_TX_LOSTCRS 8'h10
`define EFSC_OFS_TX_DEFER 8'h14
`define EFSC_OFS_TX_SINGLE 8'h18
`define EFSC_OFS_TX_MULTI 8'h1C
`define EFSC_OFS_TX_TOTCOLL 8'h20
`define EFSC_OFS_RX_GOOD 8'h24
`define EFSC_OFS_RX_CRC 8'h28
`define EFSC_OFS_RX_ALIGN 8'h2C
`define EFSC_OFS_RX_RESRC 8'h30
`define EFSC_OFS_RX_OVERRUN 8'h34
`define EFSC_OFS_RX_COLL 8'h38
`define EFSC_OFS_RX_SHORT 8'h3C
`define EFSC_OFS_FC_TX_PAUSE 8'h40
`define EFSC_OFS_FC_RX_PAUSE 8'h44
`define EFSC_OFS_FC_RX_UNSUP 8'h48
`define EFSC_OFS_RX_MGMT 8'h4C
`define EFSC_OFS_TX_MGMT 8'h50

// ****************************************************************
// dump sizes
// ****************************************************************
`define EFSC_WORDS_BASIC 5'h10
`define EFSC_WORDS_EXT 5'h15

// ****************************************************************
// apb register offsets, fields, reset values
// ****************************************************************
`define EFSC_REG_CTRL 8'h00
`define EFSC_REG_DUMP_BASE 8'h04
`define EFSC_REG_CMD 8'h08
`define EFSC_REG_STATUS 8'h0C
`define EFSC_CTRL_EXT_BIT 0
`define EFSC_CTRL_MGMT_BIT 1
`define EFSC_CTRL_SAVEBAD_BIT 2
`define EFSC_CTRL_RST 3'h0
`define EFSC_BASE_RST 32'h0000_0000
`define EFSC_STAT_BUSY_BIT 0
`define EFSC_STAT_DUMPS_LSB 16

// ****************************************************************
// command unit opcodes
// ****************************************************************
`define EFSC_OP_DUMP 4'h5
`define EFSC_OP_DUMP_RESET 4'h7

`endif

/* core/efsc_pkg.sv */
`default_nettype none
package efsc_pkg;
  // transmit frame outcome, valid while done is high
  typedef struct packed {
    logic done;
    logic good;
    logic excess_collision_abort;
    logic late_collision_abort;
    logic underrun;
    logic lost_carrier;
    logic deferred;
    logic flow_pause;
    logic mgmt;
    logic [4:0] coll_count;
  } efsc_tx_rpt_t;

  // receive frame outcome, valid while done is high
  typedef struct packed {
    logic done;
    logic good;
    logic crc_err;
    logic align_err;
    logic short_frame;
    logic resource_err;
    logic bad_frame;
    logic overrun;
    logic receive_collision_seen;
    logic flow_pause;
    logic flow_unsup;
    logic mgmt;
  } efsc_rx_rpt_t;

  // one word written to host memory during a dump
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } efsc_dump_t;

  typedef enum logic [1:0] {EFSC_IDLE, EFSC_LOAD, EFSC_WRITE} efsc_state_t;
endpackage : efsc_pkg
`default_nettype wire

/* verification/efsc_host_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// host memory that takes the dump words
// ****
module efsc_host_mem
  import efsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire efsc_dump_t dump_i,
  input wire logic dump_valid_i,
  output logic dump_ready_o,
  input wire logic slow_i,
  input wire logic [31:0] base_i,
  input wire logic [4:0] peek_i,
  output logic [31:0] peek_o,
  output logic [31:0] words_o,
  output logic bad_addr_o
);
  logic [31:0] mem_r [0:31];
  logic [31:0] lfsr_r;
  logic [31:0] ofs;

  // byte offset of the offered word from the dump base
  assign ofs = dump_i.addr - base_i;
  assign peek_o = mem_r[peek_i];

  // accept words, stalling on a pseudo-random pattern when slow
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lfsr_r <= 32'h0000_005D;
      dump_ready_o <= 1'b0;
      words_o <= 32'h0;
      bad_addr_o <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      dump_ready_o <= ~slow_i | lfsr_r[3];
      if (dump_valid_i && dump_ready_o) begin
        words_o <= words_o + 32'h1;
        if (ofs[31:7] != 25'h0 || ofs[1:0] != 2'h0) bad_addr_o <= 1'b1;
        else mem_r[ofs[6:2]] <= dump_i.data;
      end
    end
  end
endmodule : efsc_host_mem
`default_nettype wire

/* verification/efsc_stat_counters_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "efsc_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end

module efsc_stat_counters_tb
  import efsc_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, take_cmd = 1'b0, traffic = 1'b0;
  logic slow = 1'b0, pready, pslverr, dvalid, dready, bad_addr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, base = 32'h0, seed = 32'h5E, prdata, words, peek_d;
  logic [4:0] peek = 5'h00;
  logic [2:0] ctrl = 3'h0;
  efsc_tx_rpt_t tx_rpt = '0;
  efsc_rx_rpt_t rx_rpt = '0;
  efsc_dump_t dump;
  efsc_tx_rpt_t txq[$];
  efsc_rx_rpt_t rxq[$];
  logic [31:0] exp_c [0:20];
  logic [31:0] snap [0:20];
  int error_cnt = 0;
  int check_count = 0;
  localparam logic [13:0] CTX [6] = '{14'h3001, 14'h3102, 14'h2E1F, 14'h30E0, 14'h1FFF, 14'h3000};
  localparam logic [11:0] CRX [6] = '{12'hB80, 12'hB00, 12'h900, 12'h860, 12'hC1F, 12'h840};
  localparam logic [2:0] CTAB [6] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h6, 3'h5};

  efsc_stat_counters dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tx_rpt_i(tx_rpt), .rx_rpt_i(rx_rpt),
    .dump_o(dump), .dump_valid_o(dvalid), .dump_ready_i(dready));
  efsc_host_mem mem_u (.mclk_i(mclk_i), .rst_i(rst_i), .dump_i(dump), .dump_valid_i(dvalid),
    .dump_ready_o(dready), .slow_i(slow), .base_i(base), .peek_i(peek), .peek_o(peek_d),
    .words_o(words), .bad_addr_o(bad_addr));

  always #20 mclk_i = ~mclk_i;

  // ****
  // stimulus helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // number of words a dump writes for a control setting
  function automatic logic [31:0] dump_len(input logic [2:0] c);
    return (c[1:0] != 2'h0) ? 32'h0000_0015 : 32'h0000_0010;
  endfunction : dump_len

  // frame reports: queued corners first, then random traffic
  always @(posedge mclk_i) begin
    if (txq.size() > 0) begin
      tx_rpt <= txq.pop_front();
      rx_rpt <= rxq.pop_front();
    end else if (traffic) begin
      tx_rpt <= efsc_tx_rpt_t'(rnd() >> 5);
      rx_rpt <= efsc_rx_rpt_t'(rnd() >> 9);
    end else begin
      tx_rpt <= '0;
      rx_rpt <= '0;
    end
  end

  // expected counters follow each report that the design samples
  always @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 21; i++) exp_c[i] = 32'h0;
    end else begin
      if (take_cmd && psel && penable && pwrite && pready === 1'b1) begin
        snap = exp_c;
        take_cmd = 1'b0;
        if (pwdata[3:0] == `EFSC_OP_DUMP_RESET) for (int i = 0; i < 21; i++) exp_c[i] = 32'h0;
      end
      if (tx_rpt.done) begin
        exp_c[0] += 32'(tx_rpt.good);
        exp_c[1] += 32'(tx_rpt.excess_collision_abort);
        exp_c[2] += 32'(tx_rpt.late_collision_abort);
        exp_c[3] += 32'(tx_rpt.underrun);
        exp_c[4] += 32'(tx_rpt.lost_carrier & tx_rpt.good);
        exp_c[5] += 32'(tx_rpt.deferred);
        exp_c[6] += 32'(tx_rpt.good && tx_rpt.coll_count == 5'h01);
        exp_c[7] += 32'(tx_rpt.good && tx_rpt.coll_count > 5'h01);
        exp_c[8] += 32'(tx_rpt.coll_count);
        exp_c[16] += 32'(tx_rpt.flow_pause);
        exp_c[20] += 32'(tx_rpt.mgmt);
      end
      if (rx_rpt.done) begin
        exp_c[9] += 32'(rx_rpt.good);
        exp_c[10] += 32'(rx_rpt.crc_err & ~rx_rpt.align_err & ~rx_rpt.short_frame);
        exp_c[11] += 32'(rx_rpt.crc_err & rx_rpt.align_err & ~rx_rpt.short_frame);
        exp_c[15] += 32'(rx_rpt.short_frame);
        exp_c[12] += 32'(rx_rpt.resource_err & ~(ctrl[2] & rx_rpt.bad_frame));
        exp_c[13] += 32'(rx_rpt.overrun);
        exp_c[14] += 32'(rx_rpt.receive_collision_seen);
        exp_c[17] += 32'(rx_rpt.flow_pause);
        exp_c[18] += 32'(rx_rpt.flow_unsup);
        exp_c[19] += 32'(rx_rpt.mgmt);
      end
    end
  end

  // ****
  // apb master and checks
  // ****
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    if (!xe) `CHK(rd, x)
    `CHK(e, xe)
  endtask : rdc

  // issue a dump, wait for it to finish and compare the memory image
  task automatic do_dump(input logic [3:0] op, input logic dup);
    logic [31:0] st0, st1, w0;
    logic e;
    int k;
    apb(1'b0, `EFSC_REG_STATUS, 32'h0, st0, e);
    w0 = words;
    take_cmd = 1'b1;
    wr(`EFSC_REG_CMD, {28'h0, op});
    if (dup) wr(`EFSC_REG_CMD, {28'h0, `EFSC_OP_DUMP_RESET}); // ignored while busy
    k = 0;
    do begin
      apb(1'b0, `EFSC_REG_STATUS, 32'h0, st1, e);
      k++;
    end while (st1[0] !== 1'b0 && k < 300);
    if (st1[0] !== 1'b0) error_cnt++;
    `CHK(st1[31:16], st0[31:16] + 16'h1)
    `CHK(words - w0, dump_len(ctrl))
    for (int i = 0; i < 21; i++) begin
      if (32'(i) < words - w0) begin
        peek = 5'(i);
        #1;
        `CHK(peek_d, snap[i])
      end
    end
    `CHK(bad_addr, 1'b0)
  endtask : do_dump

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ****
  // main sequence
  // ****
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdc(`EFSC_REG_CTRL, 32'h0, 1'b0);
    rdc(`EFSC_REG_DUMP_BASE, 32'h0, 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    wr(`EFSC_REG_CMD, 32'h3);
    rdc(`EFSC_REG_STATUS, 32'h0, 1'b0);
    rdc(`EFSC_REG_CMD, 32'h0, 1'b0);
    base = 32'h0000_2000 | (rnd() & 32'h0000_0FF0);
    wr(`EFSC_REG_DUMP_BASE, base | 32'h3);
    rdc(`EFSC_REG_DUMP_BASE, base, 1'b0);
    do_dump(`EFSC_OP_DUMP, 1'b0);
    for (int r = 0; r < 6; r++) begin
      traffic = 1'b0;
      repeat (3) @(posedge mclk_i);
      wr(`EFSC_REG_CTRL, {29'h0, CTAB[r]});
      ctrl = CTAB[r];
      rdc(`EFSC_REG_CTRL, {29'h0, ctrl}, 1'b0);
      for (int i = 0; i < 6; i++) begin
        txq.push_back(efsc_tx_rpt_t'(CTX[i]));
        rxq.push_back(efsc_rx_rpt_t'(CRX[i]));
      end
      traffic = 1'b1;
      slow = r[0];
      repeat (50 + rnd() % 100) @(posedge mclk_i);
      do_dump(r[1] ? `EFSC_OP_DUMP_RESET : `EFSC_OP_DUMP, r == 2 || r == 5);
    end
    traffic = 1'b0;
    repeat (3) @(posedge mclk_i);
    do_dump(`EFSC_OP_DUMP, 1'b0);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    ctrl = 3'h0;
    base = 32'h0;
    rdc(`EFSC_REG_CTRL, 32'h0, 1'b0);
    rdc(`EFSC_REG_STATUS, 32'h0, 1'b0);
    do_dump(`EFSC_OP_DUMP, 1'b0);
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    #(40 * 60000);
    error_cnt++;
    report_and_stop();
  end
endmodule : efsc_stat_counters_tb
`default_nettype wire
